// ===== design/tds_consts.vh
`ifndef TDS_CONSTS_VH
`define TDS_CONSTS_VH
// register indices
`define TDS_ADDR_INDEX 8'h38
`define TDS_ADDR_STATUS 8'h3f
// status bit positions
`define TDS_ST_BANK 0
`define TDS_ST_UNLISTED 1
`define TDS_ST_PRESENT 2
`define TDS_ST_TRANS 3
`define TDS_ST_FULL 4
`define TDS_ST_SWITCH 5
// group search select codes
`define TDS_GRP_OFF 2'h0
`define TDS_GRP_SECOND 2'h1
`define TDS_GRP_FIRST 2'h2
// table geometry
`define TDS_TABLE_LAST 5'h1f
`define TDS_IDX_W 5
// absence timeout in measurement periods
`define TDS_ABSENCE_PERIODS 4'h3
// measurement periods in microseconds, system clock in megahertz
`define TDS_FAST_US 4300
`define TDS_SLOW_US 8600
`define TDS_CLK_MHZ 20
`endif

// ===== design/tds_sync.v
`timescale 1ns/1ns
`default_nettype none
module tds_sync (
  // clock and reset
  input wire sys_clk_i,
  input wire rst_i,
  input wire ce_i,
  // asynchronous level in, filtered level out
  input wire async_i,
  output reg level_o
);
  reg s1;
  reg s2;
  reg s3;
  // first stage only feeds the second stage
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level_o <= 1'b0;
    end else if (ce_i) begin
      s1 <= async_i;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level_o <= s3;
      end
    end
  end
endmodule
`default_nettype wire

// ===== design/tds_period.v
`timescale 1ns/1ns
`default_nettype none
`include "tds_consts.vh"
module tds_period #(
  parameter FAST_CYCLES = `TDS_FAST_US * `TDS_CLK_MHZ,
  parameter SLOW_CYCLES = `TDS_SLOW_US * `TDS_CLK_MHZ
) (
  // clock and reset
  input wire sys_clk_i,
  input wire rst_i,
  input wire ce_i,
  // control
  input wire run_i,
  input wire slow_i,
  // one-cycle tick at end of each measurement period
  output reg tick_o
);
  // full-width terms first, then cut to the counter width on purpose
  localparam [31:0] FAST_M1 = FAST_CYCLES - 1;
  localparam [31:0] SLOW_M1 = SLOW_CYCLES - 1;
  localparam [17:0] FAST_LAST = FAST_M1[17:0];
  localparam [17:0] SLOW_LAST = SLOW_M1[17:0];
  reg [17:0] cnt;
  wire [17:0] last = slow_i ? SLOW_LAST : FAST_LAST;
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= 18'h00000;
      tick_o <= 1'b0;
    end else if (ce_i) begin
      tick_o <= 1'b0;
      if (!run_i) begin
        cnt <= 18'h00000;
      end else if (cnt >= last) begin
        cnt <= 18'h00000;
        tick_o <= 1'b1;
      end else begin
        cnt <= cnt + 18'h00001;
      end
    end
  end
endmodule
`default_nettype wire

// ===== design/tds_status.v
// Function
// - index register shows matched table position, five bits, zero is first
// - index upper three bits always read zero
// - index updates together with the matched tone word
// - status bits seven and six always read zero
// - tone present and different listed tone sets tone switch flag
// - thirty-two entries loaded sets table full flag
// - power-down keeps full flag; erase or full reset clears it
// - leaving tone-present or group-matched word change sets transition flag
// - present flag is one from detection until the absence timer expires, zero otherwise
// - from absent, listed in-group tone sets present and interrupts
// - from absent, unlisted tone enters present with unknown flag, no interrupt
// - from absent, listed out-of-group tone ignored, no interrupt
// - from present, any other tone keeps present and interrupts
// - tone loss runs fixed absence timer, then return to absent
// - unknown flag set on unlisted, cleared on listed tone except out-of-group from absent
// - bank flag reports selected table at match, no interrupt
// - interrupt low on transition, switch, or full rising edge
// - status read releases interrupt, clears transition and switch
// - present, unknown, bank refreshed once per measurement period
// - powered-down status reads 000x0000, full flag kept
// - zero group select disables decode and clears five flags
// - matched word held valid for one measurement period
// - entries compared from zero, first match wins, up to thirty-one
// - group select 00 off, 01 second, 10 first, 11 illegal
`timescale 1ns/1ns
`default_nettype none
`include "tds_consts.vh"
module tds_status (
  // clock, reset, enable
  input wire sys_clk_i,
  input wire rst_i,
  input wire ce_i,
  // configuration from the control registers
  input wire [1:0] group_sel_i,
  input wire bank_sel_i,
  input wire slow_i,
  input wire power_down_i,
  input wire general_reset_i,
  input wire table_erase_i,
  input wire [5:0] load_count_i,
  // measurement result, one per period, from the matcher
  input wire meas_valid_i,
  input wire tone_seen_i,
  input wire listed_i,
  input wire in_group_i,
  input wire [`TDS_IDX_W-1:0] match_index_i,
  input wire [15:0] match_word_i,
  // host register read port
  input wire rd_i,
  input wire [7:0] rd_addr_i,
  output reg [7:0] rd_data_o,
  // matched tone word and interrupt
  output reg [15:0] tone_word_o,
  output wire interrupt_request_low_o,
  // asynchronous pin: tone energy present on the input
  input wire tone_pin_i
);
  localparam [2:0] ST_ABSENT = 3'h1;
  localparam [2:0] ST_PRESENT = 3'h2;
  localparam [2:0] ST_HOLD = 3'h4;

  reg [2:0] state;
  reg [2:0] next_state;
  reg [3:0] absence_cnt;
  reg [4:0] index;
  reg present;
  reg unknown;
  reg bank;
  reg trans;
  reg tsw;
  reg full;
  reg full_d;
  reg irq_low;
  reg [`TDS_IDX_W-1:0] last_index;
  wire tone_sync;
  wire tick;
  wire decoding;
  wire seen;
  wire status_read;

  // ------------------------------------------------------------
  // pin synchroniser and period timer
  // ------------------------------------------------------------
  tds_sync u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .async_i(tone_pin_i),
    .level_o(tone_sync)
  );

  tds_period u_period (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .run_i(decoding),
    .slow_i(slow_i),
    .tick_o(tick)
  );

  // group decode
  // 11 is illegal; treated as off so no double-group search occurs
  assign decoding = !power_down_i &&
    ((group_sel_i == `TDS_GRP_SECOND) || (group_sel_i == `TDS_GRP_FIRST));
  // a result counts only at a period boundary with tone energy present
  assign seen = meas_valid_i && tone_sync && tick;
  assign status_read = rd_i && (rd_addr_i == `TDS_ADDR_STATUS);

  // ------------------------------------------------------------
  // decode state machine
  // ------------------------------------------------------------
  always @* begin
    next_state = state;
    case (state)
      ST_ABSENT: begin
        if (seen && (!listed_i || in_group_i)) begin
          next_state = ST_PRESENT;
        end
      end
      ST_PRESENT: begin
        if (tick && !(meas_valid_i && tone_sync)) begin
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (seen) begin
          next_state = ST_PRESENT;
        end else if (tick && absence_cnt == `TDS_ABSENCE_PERIODS) begin
          next_state = ST_ABSENT;
        end
      end
      default: begin
        next_state = ST_ABSENT;
      end
    endcase
  end

  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_ABSENT;
      absence_cnt <= 4'h0;
      present <= 1'b0;
      unknown <= 1'b0;
      bank <= 1'b0;
      trans <= 1'b0;
      tsw <= 1'b0;
      index <= 5'h00;
      last_index <= 5'h00;
      tone_word_o <= 16'h0000;
    end else if (ce_i) begin
      if (!decoding) begin
        state <= ST_ABSENT;
        absence_cnt <= 4'h0;
        present <= 1'b0;
        unknown <= 1'b0;
        bank <= 1'b0;
        trans <= 1'b0;
        tsw <= 1'b0;
      end else begin
        state <= next_state;
        if (state != ST_HOLD) begin
          absence_cnt <= 4'h0;
        end else if (tick) begin
          absence_cnt <= absence_cnt + 4'h1;
        end
        if (seen && (state != ST_ABSENT || !listed_i || in_group_i)) begin
          present <= 1'b1;
          unknown <= !listed_i;
          if (listed_i) begin
            bank <= bank_sel_i;
            index <= match_index_i;
            tone_word_o <= match_word_i;
            last_index <= match_index_i;
          end
        end else if (tick && state == ST_HOLD && absence_cnt == `TDS_ABSENCE_PERIODS &&
                     !seen) begin
          present <= 1'b0;
        end
        // set wins over the status-read clear
        // transition flag
        if ((seen && state == ST_ABSENT && listed_i && in_group_i) ||
            (seen && state != ST_ABSENT && listed_i && in_group_i &&
             match_index_i != last_index) ||
            (tick && state == ST_HOLD && absence_cnt == `TDS_ABSENCE_PERIODS && !seen)) begin
          trans <= 1'b1;
        end else if (status_read) begin
          trans <= 1'b0;
        end
        if (seen && state != ST_ABSENT && (match_index_i != last_index || !listed_i)) begin
          tsw <= 1'b1;
        end else if (status_read) begin
          tsw <= 1'b0;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // table full flag and interrupt
  // ------------------------------------------------------------
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      full <= 1'b0;
      full_d <= 1'b0;
      irq_low <= 1'b0;
    end else if (ce_i) begin
      full_d <= full;
      if (general_reset_i || table_erase_i) begin
        full <= 1'b0;
      end else if (load_count_i[5]) begin
        full <= 1'b1;
      end
      if (full && !full_d) begin
        irq_low <= 1'b1;
      end else if (status_read) begin
        irq_low <= 1'b0;
      end
    end
  end

  // asserted low while any pending source stands
  assign interrupt_request_low_o = !(irq_low || trans || tsw);

  // ------------------------------------------------------------
  // register read port
  // ------------------------------------------------------------
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_o <= 8'h00;
    end else if (ce_i && rd_i) begin
      case (rd_addr_i)
        `TDS_ADDR_INDEX: rd_data_o <= {3'h0, index};
        `TDS_ADDR_STATUS: rd_data_o <= {2'h0, tsw, full, trans, present, unknown, bank};
        default: rd_data_o <= 8'h00;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== tb/tds_host.sv
`timescale 1ns/1ns
`default_nettype none
module tds_host (
  // clock
  input wire logic sys_clk_i,
  // read strobe and index
  output logic rd_o,
  output logic [7:0] addr_o
);
  initial begin
    rd_o = 1'b0;
    addr_o = 8'h00;
  end
  // address inverted on release so no stale index is seen
  task automatic read(input logic [7:0] a);
    @(posedge sys_clk_i);
    rd_o <= 1'b1;
    addr_o <= a;
    @(posedge sys_clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
  endtask
endmodule
`default_nettype wire

// ===== tb/tds_status_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module tds_status_monitor (
  // clock and reset
  input wire sys_clk_i,
  input wire rst_i,
  // watched ports
  input wire ce_i,
  input wire [1:0] group_sel_i,
  input wire power_down_i,
  input wire general_reset_i,
  input wire table_erase_i,
  input wire [5:0] load_count_i,
  input wire rd_i,
  input wire [7:0] rd_addr_i,
  input wire [7:0] rd_data_o,
  input wire [15:0] tone_word_o,
  input wire interrupt_request_low_o
);
  // ----
  // checks
  // ----
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  wire rs = rd_i && ce_i && rd_addr_i == 8'h3f;
  wire ri = rd_i && ce_i && rd_addr_i == 8'h38;
  wire irq = interrupt_request_low_o;
  property p_idx; ri |=> rd_data_o[7:5] == 3'h0; endproperty
  a_idx: assert property (p_idx) else $error("index top set");
  property p_top; rs |=> rd_data_o[7:6] == 2'h0; endproperty
  a_top: assert property (p_top) else $error("status top set");
  property p_off;
    ce_i && group_sel_i == 2'h0 ##1 rs && group_sel_i == 2'h0 |=> (rd_data_o & 8'hef) == 8'h00;
  endproperty
  a_off: assert property (p_off) else $error("off flags kept");
  property p_ill;
    ce_i && group_sel_i == 2'h3 ##1 rs && group_sel_i == 2'h3 |=> (rd_data_o & 8'hef) == 8'h00;
  endproperty
  a_ill: assert property (p_ill) else $error("code 3 decoded");
  property p_pd; ce_i && power_down_i ##1 rs && power_down_i |=> (rd_data_o & 8'hef) == 8'h00;
  endproperty
  a_pd: assert property (p_pd) else $error("pd preset");
  // a full-flag edge in the same cycle may pull it low again
  property p_rel; rs && group_sel_i == 2'h0 && $stable(load_count_i) |=> irq; endproperty
  a_rel: assert property (p_rel) else $error("irq kept");
  property p_full;
    $rose(load_count_i[5]) && !table_erase_i && !general_reset_i |-> ##[0:2] !irq;
  endproperty
  a_full: assert property (p_full) else $error("full no irq");
  property p_hold; $fell(irq) |=> $stable(tone_word_o)[*8]; endproperty
  a_hold: assert property (p_hold) else $error("word moved");
  property p_clr; (table_erase_i || general_reset_i) && !load_count_i[5] ##2 rs |=> !rd_data_o[4];
  endproperty
  a_clr: assert property (p_clr) else $error("full kept");
  c_dec: cover property (rs ##1 rd_data_o[2]);
  c_irq: cover property ($fell(irq));
  c_idx: cover property (ri);
endmodule
bind tds_status tds_status_monitor mon (
  .sys_clk_i, .rst_i, .ce_i, .group_sel_i, .power_down_i, .general_reset_i, .table_erase_i,
  .load_count_i, .rd_i, .rd_addr_i, .rd_data_o, .tone_word_o, .interrupt_request_low_o
);
`default_nettype wire

// ===== tb/tds_status_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tds_status_tb_top;
  logic sys_clk_i, rst_i, bank_sel_i, power_down_i, general_reset_i, table_erase_i;
  logic meas_valid_i, listed_i, in_group_i, tone_pin_i, rd_i, pend;
  logic [1:0] group_sel_i;
  logic [5:0] load_count_i;
  logic [4:0] match_index_i, e_idx;
  logic [7:0] rd_addr_i, rd_data_o;
  logic [15:0] match_word_i, tone_word_o, e_w, n;
  logic [31:0] lf;
  wire interrupt_request_low_o;
  int bad_count, compares, i;
  logic [15:0] notes[$];
  tds_status dut (
    .sys_clk_i, .rst_i, .ce_i(1'b1), .group_sel_i, .bank_sel_i, .slow_i(1'b0),
    .power_down_i, .general_reset_i, .table_erase_i, .load_count_i, .meas_valid_i,
    .tone_seen_i(1'b0), .listed_i, .in_group_i, .match_index_i, .match_word_i, .rd_i,
    .rd_addr_i, .rd_data_o, .tone_word_o, .interrupt_request_low_o, .tone_pin_i
  );
  tds_host host (.sys_clk_i, .rd_o(rd_i), .addr_o(rd_addr_i));
  always #25 sys_clk_i = ~sys_clk_i;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test;
    if (bad_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic step;
    @(posedge sys_clk_i);
  endtask
  // note masked expectation, then let the host read
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    notes.push_back({m, e & m});
    host.read(a);
  endtask
  task automatic irq(input logic e);
    @(negedge sys_clk_i);
    check("irq", {15'h0, interrupt_request_low_o}, {15'h0, e});
  endtask
  // ----
  // read data watcher
  // ----
  always @(negedge sys_clk_i) begin
    if (pend) begin
      n = notes.pop_front();
      check("rd_data_o", {8'h0, rd_data_o & n[15:8]}, {8'h0, n[7:0]});
    end
    pend = rd_i;
  end
  // one fast period is 86000 cycles, so allow one plus a small margin
  initial begin
    repeat (95000) step;
    bad_count++;
    stop_test;
  end
  initial begin
    sys_clk_i = 1'b0;
    rst_i = 1'b1;
    {bank_sel_i, power_down_i, general_reset_i, table_erase_i} = 4'h0;
    {meas_valid_i, listed_i, in_group_i, tone_pin_i, pend} = 5'h00;
    group_sel_i = 2'h0;
    load_count_i = 6'h00;
    match_index_i = 5'h00;
    match_word_i = 16'h0000;
    lf = 32'h0001180e;
    repeat (20) step;
    rst_i <= 1'b0;
    rd(8'h3f, 8'hfe, 8'h00);
    rd(8'h38, 8'he0, 8'h00);
    rd(8'h00, 8'hff, 8'h00);
    load_count_i <= 6'h20;
    repeat (3) step;
    irq(1'b0);
    rd(8'h3f, 8'hfe, 8'h10);
    irq(1'b1);
    step;
    power_down_i <= 1'b1;
    rd(8'h3f, 8'hff, 8'h10);
    power_down_i <= 1'b0;
    load_count_i <= 6'h00;
    table_erase_i <= 1'b1;
    step;
    table_erase_i <= 1'b0;
    rd(8'h3f, 8'hfe, 8'h00);
    load_count_i <= 6'h20;
    repeat (3) step;
    irq(1'b0);
    step;
    general_reset_i <= 1'b1;
    load_count_i <= 6'h00;
    step;
    general_reset_i <= 1'b0;
    rd(8'h3f, 8'hfe, 8'h00);
    irq(1'b1);
    step;
    group_sel_i <= 2'h3;
    rd(8'h3f, 8'hef, 8'h00);
    lf = lfsr(lf);
    e_idx = lf[4:0];
    e_w = lf[31:16];
    group_sel_i <= 2'h2;
    bank_sel_i <= 1'b1;
    {meas_valid_i, listed_i, in_group_i, tone_pin_i} <= 4'hf;
    match_index_i <= e_idx;
    match_word_i <= e_w;
    for (i = 0; i < 90000 && interrupt_request_low_o !== 1'b0; i++)
      @(negedge sys_clk_i);
    check("tone_word_o", tone_word_o, e_w);
    step;
    rd(8'h38, 8'hff, {3'h0, e_idx});
    rd(8'h3f, 8'hff, 8'h0d);
    rd(8'h3f, 8'hff, 8'h05);
    irq(1'b1);
    step;
    // host clears decoder history, over ten microseconds
    group_sel_i <= 2'h0;
    rd(8'h3f, 8'hff, 8'h00);
    repeat (210) step;
    group_sel_i <= 2'h2;
    step;
    rd(8'h3f, 8'hff, 8'h00);
    repeat (2) step;
    stop_test;
  end
endmodule
`default_nettype wire
